// ### dv/smi_entry_bench.sv
// bench for the management interrupt entry block
`timescale 1ns/100ps
`default_nettype none
module smi_entry_bench;
   import smi_pkg::*;
   // ==========================================
   // signals
   logic core_clk = 1'b0, rst = 1'b1, mgmt_irq_n = 1'b1, lic_smi_msg = 1'b0;
   logic insn_boundary = 1'b1, locked_seq = 1'b0, nmi_pending = 1'b0, shutdown = 1'b0;
   logic resume = 1'b0, dual_present = 1'b0, owner = 1'b1, tcr_we = 1'b0;
   logic wb_busy = 1'b0, slow = 1'b0, clr = 1'b0, bus_idle = 1'b1;
   logic [31:0] tcr_wdata = 32'h0;
   logic [31:0] base = 32'h00050000;
   logic mgmt_active_n, dual_primary_n, mem_req, mem_write, fetch_req, pseudo_real;
   logic in_mgmt, nmi_taken, io_restart_en, program_return, burst_ready_n_n, wbe_n;
   logic [31:0] mem_addr, fetch_addr, first_addr, last_addr;
   logic [7:0] wr_cnt, rd_cnt;
   int errors = 0, total_checks = 0, nmi_seen = 0, pr_seen = 0;
   always #2.5 core_clk = ~core_clk;
   smi_entry smi_entry_inst (.core_clk(core_clk), .rst(rst), .mgmt_irq_n(mgmt_irq_n),
      .lic_smi_msg(lic_smi_msg), .insn_boundary(insn_boundary), .locked_seq(locked_seq),
      .nmi_pending(nmi_pending), .shutdown(shutdown), .bus_idle(bus_idle),
      .resume_from_mgmt_instruction(resume), .dual_present(dual_present), .bus_owner_cpu(owner),
      .mgmt_base(base), .tcr_we(tcr_we), .tcr_wdata(tcr_wdata), .ext_write_buffer_empty_n(wbe_n),
      .burst_ready_n(burst_ready_n_n), .mgmt_active_n(mgmt_active_n), .dual_primary_n(dual_primary_n),
      .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .pseudo_real(pseudo_real), .in_mgmt(in_mgmt), .nmi_taken(nmi_taken),
      .io_restart_en(io_restart_en), .program_return(program_return));
   smi_sys_model smi_sys_model_inst (.core_clk(core_clk), .rst(rst), .mem_req(mem_req),
      .mem_write(mem_write), .mem_addr(mem_addr), .burst_ready_n(burst_ready_n_n),
      .ext_write_buffer_empty_n(wbe_n), .wb_busy(wb_busy), .slow(slow), .clr(clr),
      .wr_cnt(wr_cnt), .rd_cnt(rd_cnt), .first_addr(first_addr), .last_addr(last_addr));
   // ==========================================
   // shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_for(input bit on_return, input int lim);
      int n;
      n = 0;
      while ((on_return ? program_return : fetch_req) !== 1'b1 && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      chk({31'h0, n < lim}, 32'h1);
   endtask : wait_for
   // pin low then high long enough to rearm
   task automatic pin(input int len);
      mgmt_irq_n = 1'b0;
      repeat (len) @(negedge core_clk);
      mgmt_irq_n = 1'b1;
      repeat (6) @(negedge core_clk);
   endtask : pin
   task automatic enter_chk(input logic [7:0] exp_rd);
      wait_for(1'b0, 900);
      chk(fetch_addr, base + HANDLER_OFS);
      chk({31'h0, pseudo_real}, 32'h1);
      chk({31'h0, mgmt_active_n}, 32'h0);
      chk({24'h0, wr_cnt}, 32'h10);
      chk({24'h0, rd_cnt}, {24'h0, exp_rd});
      chk(first_addr, base + SAVE_TOP_OFS);
      chk(last_addr, base + SAVE_TOP_OFS - 32'h0000000f);
      clr = 1'b1;
      @(negedge core_clk);
      clr = 1'b0;
   endtask : enter_chk
   task automatic leave;
      resume = 1'b1;
      @(negedge core_clk);
      resume = 1'b0;
      wait_for(1'b1, 900);
      chk({24'h0, rd_cnt}, 32'h10);
      @(negedge core_clk);
      chk({30'h0, mgmt_active_n, in_mgmt}, 32'h2);
      clr = 1'b1;
      @(negedge core_clk);
      clr = 1'b0;
   endtask : leave
   // ==========================================
   // monitors
   always @(negedge core_clk) begin
      if (!rst && mem_req) chk({31'h0, mgmt_active_n}, 32'h0);
      if (!rst && wb_busy) chk({31'h0, mgmt_active_n}, 32'h1);
      if (nmi_taken === 1'b1) nmi_seen++;
      if (program_return === 1'b1) pr_seen++;
   end
   // ==========================================
   // scenarios
   task automatic t_reset;
      chk({30'h0, io_restart_en, dual_primary_n}, 32'h0);
      tcr_wdata = 32'h00000200;
      tcr_we = 1'b1;
      @(negedge core_clk);
      tcr_we = 1'b0;
      repeat (2) @(negedge core_clk);
      chk({31'h0, io_restart_en}, 32'h1);
      tcr_wdata = 32'h0;
      tcr_we = 1'b1;
      @(negedge core_clk);
      tcr_we = 1'b0;
      repeat (2) @(negedge core_clk);
      chk({31'h0, io_restart_en}, 32'h0);
   endtask : t_reset
   task automatic t_basic;
      int pr;
      wb_busy = 1'b1;
      bus_idle = 1'b0;
      pin(1);
      repeat (30) @(negedge core_clk);
      chk({24'h0, wr_cnt}, 32'h0);
      wb_busy = 1'b0;
      repeat (10) @(negedge core_clk);
      chk({24'h0, wr_cnt}, 32'h0);
      chk({31'h0, mgmt_active_n}, 32'h1);
      bus_idle = 1'b1;
      enter_chk(8'h00);
      pin(40);
      chk({24'h0, wr_cnt}, 32'h0);
      pr = pr_seen;
      resume = 1'b1;
      @(negedge core_clk);
      resume = 1'b0;
      enter_chk(8'h10);
      chk(pr_seen, pr);
      leave();
   endtask : t_basic
   task automatic t_shut;
      shutdown = 1'b1;
      pin(2);
      repeat (30) @(negedge core_clk);
      chk({31'h0, in_mgmt}, 32'h0);
      shutdown = 1'b0;
      repeat (40) @(negedge core_clk);
      chk({24'h0, wr_cnt}, 32'h0);
   endtask : t_shut
   task automatic t_gate;
      insn_boundary = 1'b0;
      locked_seq = 1'b1;
      nmi_pending = 1'b1;
      slow = 1'b1;
      chk({31'h0, io_restart_en}, 32'h0);
      lic_smi_msg = 1'b1;
      @(negedge core_clk);
      lic_smi_msg = 1'b0;
      repeat (30) @(negedge core_clk);
      chk({24'h0, wr_cnt}, 32'h0);
      insn_boundary = 1'b1;
      repeat (30) @(negedge core_clk);
      chk({24'h0, wr_cnt}, 32'h0);
      nmi_seen = 0;
      locked_seq = 1'b0;
      enter_chk(8'h00);
      chk(nmi_seen, 0);
      nmi_pending = 1'b0;
      dual_present = 1'b1;
      owner = 1'b0;
      repeat (3) @(negedge core_clk);
      chk({31'h0, mgmt_active_n}, 32'h1);
      chk({31'h0, dual_primary_n}, 32'h1);
      owner = 1'b1;
      repeat (3) @(negedge core_clk);
      chk({31'h0, mgmt_active_n}, 32'h0);
      chk({31'h0, dual_primary_n}, 32'h0);
      dual_present = 1'b0;
      leave();
      nmi_pending = 1'b1;
      repeat (3) @(negedge core_clk);
      nmi_pending = 1'b0;
      chk({31'h0, nmi_seen != 0}, 32'h1);
   endtask : t_gate
   // ==========================================
   // run control
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   initial begin
      #100000;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      t_reset();
      t_basic();
      t_shut();
      t_gate();
      wrap_up();
   end
endmodule : smi_entry_bench
`default_nettype wire

// ### dv/smi_sys_model.sv
// chipset model answering management ram words
`timescale 1ns/100ps
`default_nettype none
module smi_sys_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // device side
   input wire logic mem_req,
   input wire logic mem_write,
   input wire logic [31:0] mem_addr,
   output logic burst_ready_n,
   output logic ext_write_buffer_empty_n,
   // bench control
   input wire logic wb_busy,
   input wire logic slow,
   input wire logic clr,
   output logic [7:0] wr_cnt,
   output logic [7:0] rd_cnt,
   output logic [31:0] first_addr,
   output logic [31:0] last_addr
);
   logic [3:0] gap;
   assign ext_write_buffer_empty_n = wb_busy;
   // ==========================================
   // one ready pulse per word, spaced past the sync delay
   always_ff @(posedge core_clk) begin
      if (rst || clr) begin
         burst_ready_n <= 1'b1;
         gap <= 4'h0;
         wr_cnt <= 8'h00;
         rd_cnt <= 8'h00;
         first_addr <= 32'h0;
         last_addr <= 32'h0;
      end else if (mem_req && gap == 4'h0) begin
         burst_ready_n <= 1'b0;
         gap <= slow ? 4'h9 : 4'h5;
         if (wr_cnt == 8'h00 && rd_cnt == 8'h00) first_addr <= mem_addr;
         last_addr <= mem_addr;
         if (mem_write) wr_cnt <= wr_cnt + 8'h01;
         else rd_cnt <= rd_cnt + 8'h01;
      end else begin
         burst_ready_n <= 1'b1;
         if (gap != 4'h0) gap <= gap - 4'h1;
      end
   end
endmodule : smi_sys_model
`default_nettype wire

// ### pkg/smi_pkg.sv
// package for the management interrupt entry block
package smi_pkg;
   // ==========================================
   // state machine
   typedef enum logic [2:0] {
      S_IDLE    = 3'b000,
      S_DRAIN   = 3'b001,
      S_SAVE    = 3'b010,
      S_ENV     = 3'b011,
      S_HANDLER = 3'b100,
      S_RESTORE = 3'b101
   } smi_state_type;
   // ==========================================
   // addresses
   localparam int ADDR_W = 32;
   localparam logic [31:0] SAVE_TOP_OFS = 32'h0000ffff;
   localparam logic [31:0] HANDLER_OFS = 32'h00008000;
   localparam logic [31:0] RESET_BASE = 32'h00030000;
   // ==========================================
   // context size and latency figures
   localparam int SAVE_WORDS = 16;
   localparam logic [4:0] SAVE_WORDS_W = 5'h10;
   localparam int ENTRY_LAT_CLK = 184;
   localparam int RESUME_LAT_CLK = 207;
   localparam logic [7:0] ENV_CYCLES = 8'h04;
   localparam logic [7:0] RESTORE_GAP = 8'h02;
   // ==========================================
   // test control register
   localparam int TCR_RESTART_BIT = 9;
   localparam logic [31:0] TCR_RESET = 32'h00000000;
   // ==========================================
   // synchroniser depth
   localparam int SYNC_STAGES = 2;
endpackage : smi_pkg

// ### verilog/smi_edge.sv
// falling edge detector with single pending latch
`timescale 1ns/100ps
`default_nettype none
module smi_edge (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // inputs
   input wire logic level_in,
   input wire logic msg_in,
   input wire logic take,
   input wire logic enable,
   // outputs
   output logic pending
);
   logic prev_ff;
   logic fall;
   assign fall = prev_ff & ~level_in;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prev_ff <= 1'b1;
      end else begin
         prev_ff <= level_in;
      end
   end
   // set wins over take
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pending <= 1'b0;
      end else if (enable && (fall || msg_in)) begin
         pending <= 1'b1;
      end else if (take) begin
         pending <= 1'b0;
      end
   end
endmodule : smi_edge
`default_nettype wire

// ### verilog/smi_entry.sv
// management interrupt entry, save, handler jump and resume sequencing
// Behaviour
// RULE1 - on request, finish outstanding bus cycles and wait for write buffer empty
// RULE2 - save context from base plus 0ffff downward like a stack
// RULE3 - enter pseudo-real management environment after save, before handler
// RULE4 - handler fetch starts at base plus 8000
// RULE5 - resume restores context, releases active output, returns to program
// RULE6 - request pin is falling-edge triggered and not maskable by software
// RULE7 - one-clock low latches; long low behaves correctly
// RULE8 - system drives request low three clocks before burst ready for boundary
// RULE9 - system returns request high four clocks to rearm detector
// RULE10 - recognise only on instruction boundary, ignoring interrupt enable flag
// RULE11 - never enter in the middle of a locked bus sequence
// RULE12 - rank above non-maskable interrupt, accept during its service
// RULE13 - block further requests from recognition until resume completes
// RULE14 - hold one pending request, serve it right after resume
// RULE15 - controller message invokes management mode like the pin
// RULE16 - no I/O restart with controller-delivered requests; io_restart_en here follows only test control bit 9, whatever the source
// RULE17 - no active output until pending writes done and buffer empty
// RULE18 - active output held from first save write to last restore read
// RULE19 - sole processor drives select low, active from entry to exit
// RULE20 - dual system drives active only in management mode and bus owner
// RULE21 - system qualifies separate active outputs with select signal
// RULE22 - entry roughly 184 clocks, return roughly 207 clocks
// RULE23 - I/O restart off after reset, enabled by test control bit 9
// RULE24 - ignore requests while in shutdown
// RULE25 - two-stage synchroniser, synchronised falling edge sets pending latch
`timescale 1ns/100ps
`default_nettype none
module smi_entry (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // request sources
   input wire logic mgmt_irq_n,
   input wire logic lic_smi_msg,
   // core status
   input wire logic insn_boundary,
   input wire logic locked_seq,
   input wire logic nmi_pending,
   input wire logic shutdown,
   input wire logic bus_idle,
   input wire logic resume_from_mgmt_instruction,
   input wire logic dual_present,
   input wire logic bus_owner_cpu,
   input wire logic [smi_pkg::ADDR_W-1:0] mgmt_base,
   // test control register write
   input wire logic tcr_we,
   input wire logic [31:0] tcr_wdata,
   // system side
   input wire logic ext_write_buffer_empty_n,
   input wire logic burst_ready_n,
   // outputs
   output logic mgmt_active_n,
   output logic dual_primary_n,
   output logic mem_req,
   output logic mem_write,
   output logic [smi_pkg::ADDR_W-1:0] mem_addr,
   output logic fetch_req,
   output logic [smi_pkg::ADDR_W-1:0] fetch_addr,
   output logic pseudo_real,
   output logic in_mgmt,
   output logic nmi_taken,
   output logic io_restart_en,
   output logic program_return
);
   import smi_pkg::*;

   // ==========================================
   // request synchronisation and latching
   logic irq_sync;
   logic wbe_sync;
   logic burst_ready_n_sync;
   logic pending;
   logic take;
   smi_state_type state_ff;
   smi_state_type nxt_state;
   logic [4:0] word_cnt_ff;
   logic [7:0] wait_cnt_ff;
   logic [8:0] lat_cnt_ff;

   smi_sync u_irq_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(mgmt_irq_n),
      .sync_out(irq_sync)
   ); // [RULE25]

   smi_sync u_wbe_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(ext_write_buffer_empty_n),
      .sync_out(wbe_sync)
   );

   smi_sync u_burst_ready_n_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(burst_ready_n),
      .sync_out(burst_ready_n_sync)
   );

   // edge and message both feed one pending latch, software cannot mask it
   smi_edge u_edge (
      .core_clk(core_clk),
      .rst(rst),
      .level_in(irq_sync),
      .msg_in(lic_smi_msg),
      .take(take),
      .enable(~shutdown),
      .pending(pending)
   ); // [RULE6] [RULE7] [RULE15] [RULE24] [RULE25]

   // ==========================================
   // recognition
   // only at a boundary, outside locks, while not already in management mode
   assign take = pending && (state_ff == S_IDLE) && insn_boundary && !locked_seq && !shutdown; // [RULE10] [RULE11] [RULE13] [RULE14]

   // management request beats a waiting non-maskable interrupt
   always_ff @(posedge core_clk) begin
      if (rst) begin
         nmi_taken <= 1'b0;
      end else begin
         nmi_taken <= nmi_pending && insn_boundary && !take && (state_ff == S_IDLE) && !pending; // [RULE12]
      end
   end

   // ==========================================
   // sequencer
   function automatic logic [ADDR_W-1:0] save_addr(input logic [ADDR_W-1:0] base, input logic [4:0] idx);
      save_addr = base + SAVE_TOP_OFS - {27'h0000000, idx};
   endfunction : save_addr

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         S_IDLE: begin
            if (take) begin
               nxt_state = S_DRAIN;
            end
         end
         S_DRAIN: begin
            if (bus_idle && !wbe_sync) begin
               nxt_state = S_SAVE; // [RULE1] [RULE17]
            end
         end
         S_SAVE: begin
            if (!burst_ready_n_sync && (word_cnt_ff == SAVE_WORDS_W - 5'h01)) begin
               nxt_state = S_ENV;
            end
         end
         S_ENV: begin
            if (wait_cnt_ff == ENV_CYCLES) begin
               nxt_state = S_HANDLER; // [RULE3]
            end
         end
         S_HANDLER: begin
            if (resume_from_mgmt_instruction) begin
               nxt_state = S_RESTORE;
            end
         end
         S_RESTORE: begin
            if (!burst_ready_n_sync && (word_cnt_ff == SAVE_WORDS_W - 5'h01)) begin
               nxt_state = S_IDLE; // [RULE5]
            end
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff <= S_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // word counter for save and restore
   always_ff @(posedge core_clk) begin
      if (rst) begin
         word_cnt_ff <= 5'h00;
      end else if (state_ff != nxt_state) begin
         word_cnt_ff <= 5'h00;
      end else if ((state_ff == S_SAVE || state_ff == S_RESTORE) && !burst_ready_n_sync) begin
         word_cnt_ff <= word_cnt_ff + 5'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wait_cnt_ff <= 8'h00;
      end else if (state_ff == S_ENV) begin
         wait_cnt_ff <= wait_cnt_ff + 8'h01;
      end else begin
         wait_cnt_ff <= 8'h00;
      end
   end

   // ==========================================
   // memory side of save and restore
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mem_req <= 1'b0;
         mem_write <= 1'b0;
         mem_addr <= '0;
      end else begin
         mem_req <= (nxt_state == S_SAVE) || (nxt_state == S_RESTORE);
         mem_write <= (nxt_state == S_SAVE);
         // restore reads from the top too, mirror of the save stack
         if (state_ff != nxt_state) begin
            mem_addr <= save_addr(mgmt_base, 5'h00); // [RULE2]
         end else if (!burst_ready_n_sync) begin
            mem_addr <= save_addr(mgmt_base, word_cnt_ff + 5'h01); // [RULE2]
         end
      end
   end

   // handler fetch
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fetch_req <= 1'b0;
         fetch_addr <= '0;
         pseudo_real <= 1'b0;
      end else begin
         fetch_req <= (state_ff == S_ENV) && (nxt_state == S_HANDLER);
         fetch_addr <= mgmt_base + HANDLER_OFS; // [RULE4]
         pseudo_real <= (nxt_state == S_ENV) || (nxt_state == S_HANDLER); // [RULE3]
      end
   end

   // mode flag, return pulse
   always_ff @(posedge core_clk) begin
      if (rst) begin
         in_mgmt <= 1'b0;
         program_return <= 1'b0;
      end else begin
         in_mgmt <= (nxt_state == S_SAVE) || (nxt_state == S_ENV) || (nxt_state == S_HANDLER) || (nxt_state == S_RESTORE);
         // a held request runs before any program instruction, so no return then
         program_return <= (state_ff == S_RESTORE) && (nxt_state == S_IDLE) && !pending; // [RULE5] [RULE14]
      end
   end

   // ==========================================
   // active output and select
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mgmt_active_n <= 1'b1;
         dual_primary_n <= 1'b0;
      end else begin
         // from first save through last restore; owner only when dual
         mgmt_active_n <= ~(((nxt_state == S_SAVE) || (nxt_state == S_ENV) || (nxt_state == S_HANDLER)
                         || (nxt_state == S_RESTORE)) && (!dual_present || bus_owner_cpu)); // [RULE18] [RULE19] [RULE20]
         dual_primary_n <= dual_present ? ~bus_owner_cpu : 1'b0; // [RULE19]
      end
   end

   // ==========================================
   // test control register, restart enable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         io_restart_en <= TCR_RESET[TCR_RESTART_BIT];
      end else if (tcr_we) begin
         io_restart_en <= tcr_wdata[TCR_RESTART_BIT]; // [RULE23]
      end
   end

   // ==========================================
   // entry and return latency
   // bus answer speed sets the real figure; only the fixed floor is checked
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lat_cnt_ff <= 9'h000;
      end else if (take || ((state_ff == S_HANDLER) && resume_from_mgmt_instruction)) begin
         lat_cnt_ff <= 9'h000; // [RULE22]
      end else if (lat_cnt_ff != 9'h1ff) begin
         lat_cnt_ff <= lat_cnt_ff + 9'h001; // [RULE22]
      end
   end

   // ==========================================
   // checks
   a_active_after_drain: assert property (@(posedge core_clk) disable iff (rst) // [RULE17]
      ($fell(mgmt_active_n) && ($past(state_ff) == S_DRAIN)) |-> (!$past(wbe_sync) && $past(bus_idle)))
      else $error("entry left drain early");
   a_drain_hold: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
      (state_ff == S_DRAIN && (wbe_sync || !bus_idle)) |=> (state_ff == S_DRAIN))
      else $error("drain left with writes pending");
   a_first_save_addr: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
      (state_ff == S_DRAIN && nxt_state == S_SAVE) |=> (mem_addr == mgmt_base + SAVE_TOP_OFS && mem_write))
      else $error("save not at top");
   a_save_stride: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
      (state_ff == S_SAVE && nxt_state == S_SAVE && !burst_ready_n_sync) |=> (mem_addr == $past(mem_addr) - 32'h00000001))
      else $error("save address not stepping down");
   a_env_pseudo: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
      (state_ff == S_ENV || state_ff == S_HANDLER) |-> pseudo_real)
      else $error("handler environment not set");
   a_handler_fetch: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
      $rose(fetch_req) |-> (fetch_addr == mgmt_base + HANDLER_OFS && pseudo_real))
      else $error("handler fetch wrong");
   a_fetch_pulse: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
      fetch_req |=> !fetch_req)
      else $error("handler fetch not a pulse");
   a_entry_latency: assert property (@(posedge core_clk) disable iff (rst) // [RULE22]
      $rose(fetch_req) |-> (lat_cnt_ff > {4'h0, SAVE_WORDS_W}))
      else $error("entry shorter than save");
   a_return_latency: assert property (@(posedge core_clk) disable iff (rst) // [RULE22]
      $rose(program_return) |-> (lat_cnt_ff > {4'h0, SAVE_WORDS_W}))
      else $error("return shorter than restore");
   a_active_in_save: assert property (@(posedge core_clk) disable iff (rst) // [RULE18]
      (state_ff == S_SAVE && !dual_present) |-> !mgmt_active_n)
      else $error("active released in save");
   a_idle_inactive: assert property (@(posedge core_clk) disable iff (rst) // [RULE19]
      (state_ff == S_IDLE && $past(state_ff) == S_IDLE) |-> mgmt_active_n)
      else $error("active while idle");
   a_nonowner_quiet: assert property (@(posedge core_clk) disable iff (rst) // [RULE20]
      ($past(dual_present) && !$past(bus_owner_cpu)) |-> mgmt_active_n)
      else $error("non-owner drove active");
   a_no_nest: assert property (@(posedge core_clk) disable iff (rst) // [RULE13]
      (state_ff != S_IDLE && state_ff != S_DRAIN) |=> (state_ff != S_DRAIN))
      else $error("nested entry");
   a_lock_respected: assert property (@(posedge core_clk) disable iff (rst) // [RULE11]
      (state_ff == S_IDLE && locked_seq) |=> state_ff == S_IDLE)
      else $error("entry inside lock");
   a_shutdown_ignored: assert property (@(posedge core_clk) disable iff (rst) // [RULE24]
      (state_ff == S_IDLE && shutdown) |=> (state_ff == S_IDLE))
      else $error("entry during shutdown");
   a_pending_served: assert property (@(posedge core_clk) disable iff (rst) // [RULE14]
      (state_ff == S_IDLE && pending && insn_boundary && !locked_seq && !shutdown) |=> (state_ff == S_DRAIN))
      else $error("held request not served");
   a_nmi_rank: assert property (@(posedge core_clk) disable iff (rst) // [RULE12]
      (state_ff == S_IDLE && pending && nmi_pending) |=> !nmi_taken)
      else $error("nmi taken over management request");
   a_restore_reads: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
      (state_ff == S_RESTORE && mem_req) |-> !mem_write)
      else $error("restore wrote memory");
   a_return_pulse: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
      program_return |-> (mgmt_active_n && !in_mgmt))
      else $error("return while still active");
   a_restart_reset: assert property (@(posedge core_clk) // [RULE23]
      $past(rst) |-> !io_restart_en)
      else $error("restart on after reset");
endmodule : smi_entry
`default_nettype wire

// ### verilog/smi_sync.sv
// two-stage synchroniser for the request pin, write buffer empty and burst ready inputs
`timescale 1ns/100ps
`default_nettype none
module smi_sync (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // data
   input wire logic async_in,
   output logic sync_out
);
   logic meta_ff;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_ff <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule : smi_sync
`default_nettype wire
